// file: verilog/cosc_control.sv
// Clamp timing, offset update and sync slicer output control
`timescale 1ns/1ps
module cosc_control (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWe,
    input  wire logic       regRe,
    output logic      [7:0] regRdata,
    input  wire logic       lineSyncChannelZero,
    input  wire logic       lineSyncChannelOne,
    input  wire logic       slicerSyncChannelZero,
    input  wire logic       slicerSyncChannelOne,
    input  wire logic       channelSelect,
    input  wire logic       clampPin,
    input  wire logic       coastPin,
    input  wire logic       vsyncPin,
    output logic      [2:0] clampActive,
    output logic      [2:0] clampToMid,
    output logic            coastActive,
    output logic            autoOffsetEn,
    output logic            offsetUpdate,
    output logic      [4:0] slicerThreshold,
    output logic            slicerOutputPin
);

    typedef struct packed {
        logic [7:0]          src;
        logic [7:0]          start;
        logic [7:0]          len;
        logic [7:0]          pol;
        logic [7:0]          test;
        logic [7:0]          sync_on_green;
        logic [7:0]          rdata;
        logic [2:0]          idle;
        logic [2:0]          prev;
        logic [2:0][7:0]     run;
        logic                hsPrev;
        logic                vsPrev;
        cosc_pkg::cosc_clamp_t st;
        logic [7:0]          cnt;
        logic [2:0]          clamp;
        logic                coast;
        logic                upd;
        logic [5:0]          updCnt;
        logic                pinOut;
    } cosc_state_t;

    cosc_state_t s_r;
    cosc_state_t s_nxt;

    logic       hsSel;
    logic       slSel;
    logic       hsAct;
    logic       trail;
    logic       lead;
    logic       clPolHigh;
    logic       coPolHigh;
    logic       extAct;
    logic       coAct;
    logic       clampNow;
    logic       clEnd;
    logic       vsRise;
    logic       sogSrc;
    logic       regenSync;
    logic       filtSync;
    logic [2:0] raw;
    logic [1:0] rate;

    // ==========================================================
    // Input channel and polarity
    assign hsSel = channelSelect ? lineSyncChannelOne : lineSyncChannelZero;
    assign slSel = channelSelect ? slicerSyncChannelOne : slicerSyncChannelZero;
    assign raw   = {coastPin, clampPin, hsSel};

    // Idle level learnt per input; active level is its opposite
    assign hsAct = hsSel ^ s_r.idle[0];
    assign trail = s_r.hsPrev & ~hsAct;
    assign lead  = ~s_r.hsPrev & hsAct;

    assign clPolHigh = s_r.pol[cosc_pkg::POL_OVR] ? s_r.pol[cosc_pkg::POL_USER]
                                                  : ~s_r.idle[1];
    assign extAct    = clampPin ^ ~clPolHigh;

    assign coPolHigh = s_r.src[cosc_pkg::SRC_COAST_OVR] ? s_r.src[cosc_pkg::SRC_COAST_POL]
                                                        : ~s_r.idle[2];
    assign coAct     = coastPin ^ ~coPolHigh;

    assign rate   = s_r.pol[cosc_pkg::POL_RATE_HI:cosc_pkg::POL_RATE_LO];
    // Vsync arrives already active high from the sync processing stage
    assign vsRise = vsyncPin & ~s_r.vsPrev;

    // ==========================================================
    // Sync regeneration
    cosc_sync_filter u_filter (
        .clk       (clk),
        .rst_b     (rst_b),
        .lineEdge  (lead),
        .coasting  (s_r.coast),
        .regenSync (regenSync),
        .filtSync  (filtSync)
    );

    always_comb begin
        case (s_r.sync_on_green[1:0])
            cosc_pkg::OUT_SLICE: sogSrc = slSel;
            cosc_pkg::OUT_HSYNC: sogSrc = hsAct;
            cosc_pkg::OUT_REGEN: sogSrc = regenSync;
            cosc_pkg::OUT_FILT:  sogSrc = filtSync;
            default:             sogSrc = slSel;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt       = s_r;
        s_nxt.upd   = 1'b0;
        s_nxt.rdata = 8'h00;
        clampNow    = 1'b0;
        clEnd       = 1'b0;

        // Polarity learning: a level held for a full run is the idle level
        for (int i = 0; i < 3; i++) begin
            s_nxt.prev[i] = raw[i];
            if (raw[i] != s_r.prev[i]) begin
                s_nxt.run[i] = 8'h00;
            end else if (s_r.run[i] != cosc_pkg::POL_RUN) begin
                s_nxt.run[i] = s_r.run[i] + 8'h01;
            end else begin
                s_nxt.idle[i] = raw[i];
            end
        end
        s_nxt.hsPrev = hsAct;
        s_nxt.vsPrev = vsyncPin;

        // Internal clamp window; a zero count behaves like one
        case (s_r.st)
            cosc_pkg::CL_WAIT: begin
                if (s_r.cnt <= 8'h01) begin
                    s_nxt.st  = cosc_pkg::CL_HOLD;
                    s_nxt.cnt = s_r.len;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            cosc_pkg::CL_HOLD: begin
                if (s_r.cnt <= 8'h01) begin
                    s_nxt.st = cosc_pkg::CL_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            cosc_pkg::CL_IDLE: begin
                s_nxt.st = cosc_pkg::CL_IDLE;
            end
            default: begin
                s_nxt.st = cosc_pkg::CL_IDLE;
            end
        endcase
        if (trail) begin
            s_nxt.st  = cosc_pkg::CL_WAIT;
            s_nxt.cnt = s_r.start;
        end

        // Counter keeps running in external mode but never reaches the output
        if (s_r.src[cosc_pkg::SRC_EXT_CLAMP]) begin
            clampNow = extAct;
        end else begin
            clampNow = s_nxt.st == cosc_pkg::CL_HOLD;
        end
        s_nxt.clamp = {3{clampNow}};
        s_nxt.coast = coAct;

        // Offset update pacing
        clEnd = s_r.clamp[0] & ~clampNow;
        if (clEnd) begin
            s_nxt.updCnt = s_r.updCnt + 6'h01;
        end
        if (s_r.pol[cosc_pkg::POL_AUTO]) begin
            case (rate)
                cosc_pkg::UPD_EVERY: s_nxt.upd = clEnd;
                cosc_pkg::UPD_16:
                    s_nxt.upd = clEnd && (s_r.updCnt[3:0] == cosc_pkg::UPD_MASK_16[3:0]);
                cosc_pkg::UPD_64:
                    s_nxt.upd = clEnd && (s_r.updCnt == cosc_pkg::UPD_MASK_64);
                cosc_pkg::UPD_VSYNC: s_nxt.upd = vsRise;
                default:             s_nxt.upd = 1'b0;
            endcase
        end

        s_nxt.pinOut = s_r.sync_on_green[cosc_pkg::SOG_POL] ? sogSrc : ~sogSrc;

        // Register port
        if (regWe) begin
            case (regAddr)
                cosc_pkg::ADDR_SRC:   s_nxt.src   = regWdata;
                cosc_pkg::ADDR_START: s_nxt.start = regWdata;
                cosc_pkg::ADDR_LEN:   s_nxt.len   = regWdata;
                cosc_pkg::ADDR_POL:   s_nxt.pol   = regWdata;
                cosc_pkg::ADDR_TEST:  s_nxt.test  = regWdata;
                cosc_pkg::ADDR_SOG:   s_nxt.sync_on_green   = regWdata;
                default:              s_nxt.src   = s_r.src;
            endcase
        end
        if (regRe) begin
            case (regAddr)
                cosc_pkg::ADDR_SRC:   s_nxt.rdata = s_r.src;
                cosc_pkg::ADDR_START: s_nxt.rdata = s_r.start;
                cosc_pkg::ADDR_LEN:   s_nxt.rdata = s_r.len;
                cosc_pkg::ADDR_POL:   s_nxt.rdata = s_r.pol;
                cosc_pkg::ADDR_TEST:  s_nxt.rdata = s_r.test;
                cosc_pkg::ADDR_SOG:   s_nxt.rdata = s_r.sync_on_green;
                default:              s_nxt.rdata = 8'h00;
            endcase
        end

        if (!rst_b) begin
            s_nxt       = '0;
            s_nxt.src   = cosc_pkg::RST_SRC;
            s_nxt.start = cosc_pkg::RST_START;
            s_nxt.len   = cosc_pkg::RST_LEN;
            s_nxt.pol   = cosc_pkg::RST_POL;
            s_nxt.test  = cosc_pkg::RST_TEST;
            s_nxt.sync_on_green   = cosc_pkg::RST_SOG;
            s_nxt.idle  = 3'h7;
            s_nxt.st    = cosc_pkg::CL_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    // ==========================================================
    // Outputs
    assign regRdata        = s_r.rdata;
    assign clampActive     = s_r.clamp;
    assign clampToMid      = s_r.src[cosc_pkg::SRC_RED:cosc_pkg::SRC_BLUE];
    assign coastActive     = s_r.coast;
    assign autoOffsetEn    = s_r.pol[cosc_pkg::POL_AUTO];
    assign offsetUpdate    = s_r.upd;
    assign slicerThreshold = s_r.sync_on_green[cosc_pkg::SOG_THR_HI:cosc_pkg::SOG_THR_LO];
    assign slicerOutputPin = s_r.pinOut;

    // ==========================================================
    // Checks
    logic [8:0] edgeAge;
    logic [8:0] clampAge;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edgeAge  <= 9'h1ff;
            clampAge <= 9'h000;
        end else begin
            // Zero just after the trailing edge, so the count at the rise equals placement
            edgeAge  <= trail ? 9'h000 : (edgeAge == 9'h1ff ? edgeAge : edgeAge + 9'h001);
            clampAge <= clampActive[0] ? clampAge + 9'h001 : 9'h000;
        end
    end

    sequence clampRise;
        $rose(clampActive[0]) && !s_r.src[cosc_pkg::SRC_EXT_CLAMP];
    endsequence

    sequence clampFall;
        $fell(clampActive[0]) && !s_r.src[cosc_pkg::SRC_EXT_CLAMP] && !$past(trail);
    endsequence

    a_clamp_all_channels: assert property (@(posedge clk) disable iff (!rst_b)
        clampActive == {3{clampActive[0]}})
        else $error("Channels clamp at different times");

    a_ext_clamp_follows: assert property (@(posedge clk) disable iff (!rst_b)
        s_r.src[cosc_pkg::SRC_EXT_CLAMP] && !regWe |=> clampActive[0] == $past(extAct))
        else $error("External clamp not followed");

    a_clamp_start_delay: assert property (@(posedge clk) disable iff (!rst_b)
        clampRise |-> edgeAge == {1'b0, s_r.start})
        else $error("Clamp start delay wrong");

    a_clamp_window_len: assert property (@(posedge clk) disable iff (!rst_b)
        clampFall |-> clampAge == {1'b0, s_r.len})
        else $error("Clamp window length wrong");

    a_user_clamp_pol: assert property (@(posedge clk) disable iff (!rst_b)
        s_r.pol[cosc_pkg::POL_OVR] && s_r.src[cosc_pkg::SRC_EXT_CLAMP] && !regWe
        |=> clampActive[0] == ($past(clampPin) == $past(s_r.pol[cosc_pkg::POL_USER])))
        else $error("User clamp polarity ignored");

    a_offset_gate: assert property (@(posedge clk) disable iff (!rst_b)
        offsetUpdate |-> $past(s_r.pol[cosc_pkg::POL_AUTO]))
        else $error("Offset update while auto-offset off");

    a_offset_each_clamp: assert property (@(posedge clk) disable iff (!rst_b)
        clEnd && s_r.pol[cosc_pkg::POL_AUTO] && rate == cosc_pkg::UPD_EVERY
        |=> offsetUpdate ##1 !offsetUpdate)
        else $error("Offset not updated at clamp end");

    a_user_coast_pol: assert property (@(posedge clk) disable iff (!rst_b)
        s_r.src[cosc_pkg::SRC_COAST_OVR] && !regWe
        |=> coastActive == ($past(coastPin) == $past(s_r.src[cosc_pkg::SRC_COAST_POL])))
        else $error("User coast polarity ignored");

    a_slicer_pin_route: assert property (@(posedge clk) disable iff (!rst_b)
        !regWe |=> slicerOutputPin == ($past(sogSrc) ~^ $past(s_r.sync_on_green[cosc_pkg::SOG_POL])))
        else $error("Slicer output pin wrong");

    a_raw_hsync_chan: assert property (@(posedge clk) disable iff (!rst_b)
        s_r.sync_on_green[1:0] == cosc_pkg::OUT_HSYNC && s_r.sync_on_green[cosc_pkg::SOG_POL] && !regWe
        |=> slicerOutputPin == ($past(channelSelect) ? $past(lineSyncChannelOne)
            : $past(lineSyncChannelZero)) ^ $past(s_r.idle[0]))
        else $error("Raw Hsync from wrong channel");

endmodule : cosc_control

// file: verilog/cosc_pkg.sv
// Shared constants for the clamp, offset and sync slicer control block
//
// Contract
// - Clamp source bit: 0 internal counted clamp, 1 external clamp pin; resets 0
// - While the selected clamp is active all three channels clamp together
// - Per-channel target bits red, green, blue: 0 ground, 1 midscale; reset 0
// - Internal clamp starts placement pixel periods after Hsync trailing edge; reset 8
// - Internal clamp lasts duration pixel periods, reset 20; zero never written; the code accepts zero and treats it as one
// - External clamp mode ignores placement and duration registers
// - Clamp polarity override: 0 device detects polarity, 1 user bit decides
// - User clamp polarity: 0 active low, 1 active high; resets 1
// - Auto-offset enable bit, reset 0, picks automatic or manual offset
// - Update rate: every clamp, every 16, every 64, once per Vsync; reset 11
// - Five-bit slicer threshold, 8 mV steps from 8 to 256 mV; reset 15
// - Slicer output polarity bit: 0 active low, 1 active high; reset 0
// - Output select: raw slicer, raw Hsync, regenerated sync, filtered sync
// - Regenerated sync fills missing pulses; filtered sync drops out-of-window ones
// - User coast polarity: 0 negative-going, 1 positive-going coast input
// - User coast polarity, reset 1, only counts while coast override is 1
// - Raw slicer sync and raw Hsync come from the active input channel
package cosc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_SRC   = 8'h18;
    localparam logic [7:0] ADDR_START = 8'h19;
    localparam logic [7:0] ADDR_LEN   = 8'h1a;
    localparam logic [7:0] ADDR_POL   = 8'h1b;
    localparam logic [7:0] ADDR_TEST  = 8'h1c;
    localparam logic [7:0] ADDR_SOG   = 8'h1d;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] RST_SRC   = 8'h20;
    localparam logic [7:0] RST_START = 8'h08;
    localparam logic [7:0] RST_LEN   = 8'h14;
    localparam logic [7:0] RST_POL   = 8'h58;
    localparam logic [7:0] RST_TEST  = 8'h00;
    localparam logic [7:0] RST_SOG   = 8'h78;

    // ==========================================================
    // Field positions
    localparam int SRC_COAST_OVR = 6;
    localparam int SRC_COAST_POL = 5;
    localparam int SRC_EXT_CLAMP = 4;
    localparam int SRC_RED       = 3;
    localparam int SRC_BLUE      = 1;
    localparam int POL_OVR       = 7;
    localparam int POL_USER      = 6;
    localparam int POL_AUTO      = 5;
    localparam int POL_RATE_HI   = 4;
    localparam int POL_RATE_LO   = 3;
    localparam int SOG_THR_HI    = 7;
    localparam int SOG_THR_LO    = 3;
    localparam int SOG_POL       = 2;

    // ==========================================================
    // Codes
    localparam logic [1:0] UPD_EVERY = 2'h0;
    localparam logic [1:0] UPD_16    = 2'h1;
    localparam logic [1:0] UPD_64    = 2'h2;
    localparam logic [1:0] UPD_VSYNC = 2'h3;
    localparam logic [1:0] OUT_SLICE = 2'h0;
    localparam logic [1:0] OUT_HSYNC = 2'h1;
    localparam logic [1:0] OUT_REGEN = 2'h2;
    localparam logic [1:0] OUT_FILT  = 2'h3;

    typedef enum logic [1:0] {
        CL_IDLE = 2'h0,
        CL_WAIT = 2'h1,
        CL_HOLD = 2'h3
    } cosc_clamp_t;

    // ==========================================================
    // Cycle counts
    localparam logic [5:0]  UPD_MASK_16 = 6'h0f;
    localparam logic [5:0]  UPD_MASK_64 = 6'h3f;
    localparam logic [7:0]  POL_RUN     = 8'hff;
    localparam logic [11:0] FILT_TOL    = 12'h008;
    localparam logic [11:0] AGE_MAX     = 12'hfff;
    localparam logic [3:0]  SYNC_WIDTH  = 4'h8;

endpackage : cosc_pkg

// file: verilog/cosc_sync_filter.sv
// Line sync regenerator and window filter
`timescale 1ns/1ps
module cosc_sync_filter (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic lineEdge,
    input  wire logic coasting,
    output logic      regenSync,
    output logic      filtSync
);

    typedef struct packed {
        logic [11:0] period;
        logic [11:0] age;
        logic [3:0]  wRegen;
        logic [3:0]  wFilt;
        logic        lastReal;
    } cosc_filt_t;

    cosc_filt_t s_r;
    cosc_filt_t s_nxt;
    logic       learnt;
    logic       inWin;
    logic       insert;
    logic       take;

    // ==========================================================
    // Period tracking
    always_comb begin
        s_nxt  = s_r;
        learnt = s_r.period != 12'h000;
        inWin  = (s_r.age + cosc_pkg::FILT_TOL >= s_r.period)
              && (s_r.age <= s_r.period + cosc_pkg::FILT_TOL);
        // While coasting the input is distrusted and the learnt period rules
        insert = learnt && (coasting ? s_r.age >= s_r.period
                                     : s_r.age >= s_r.period + cosc_pkg::FILT_TOL);
        // Once a period is learnt, out-of-window edges are ignored so a stray
        // pulse cannot shift the phase; a line rate changed by more than FILT_TOL is not relearnt
        take   = lineEdge && !coasting && (!learnt || inWin);
        if (s_r.age != cosc_pkg::AGE_MAX) begin
            s_nxt.age = s_r.age + 12'h001;
        end
        if (s_r.wRegen != 4'h0) begin
            s_nxt.wRegen = s_r.wRegen - 4'h1;
        end
        if (s_r.wFilt != 4'h0) begin
            s_nxt.wFilt = s_r.wFilt - 4'h1;
        end
        if (insert) begin
            // A late insert restores the expected phase for the next real edge
            s_nxt.age      = coasting ? 12'h001 : 12'h001 + cosc_pkg::FILT_TOL;
            s_nxt.wRegen   = cosc_pkg::SYNC_WIDTH;
            s_nxt.lastReal = 1'b0;
        end
        if (take) begin
            s_nxt.age      = 12'h001;
            s_nxt.wRegen   = cosc_pkg::SYNC_WIDTH;
            s_nxt.lastReal = 1'b1;
            // Only a gap between two real edges is a valid period
            if (s_r.lastReal) begin
                s_nxt.period = s_r.age;
            end
        end
        if (lineEdge && (!learnt || inWin)) begin
            s_nxt.wFilt = cosc_pkg::SYNC_WIDTH;
        end
        if (!rst_b) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign regenSync = s_r.wRegen != 4'h0;
    assign filtSync  = s_r.wFilt != 4'h0;

endmodule : cosc_sync_filter

// file: tb/cosc_video_source.sv
// Video source model: line and slicer syncs of two input channels
`timescale 1ns/1ps
module cosc_video_source #(
    parameter int LINE = 40
) (
    input  wire logic clk,
    input  wire logic drop,
    input  wire logic stray,
    output logic      lineSync0,
    output logic      lineSync1,
    output logic      slicer0,
    output logic      slicer1
);
    int phase = 0;
    initial {lineSync0, lineSync1, slicer0, slicer1} = 4'hc;
    // ==========
    // Line syncs are active low and never idle 256 cycles, so polarity learning keeps them
    always @(posedge clk) begin
        phase     <= (phase + 1) % LINE;
        lineSync0 <= !((phase < 4 && !drop) || (stray && phase >= 20 && phase < 24));
        lineSync1 <= !(phase >= LINE / 2 && phase < LINE / 2 + 4);
        slicer0   <= phase >= 10 && phase < 14;
        slicer1   <= phase >= 30 && phase < 34;
    end
endmodule : cosc_video_source

// file: tb/cosc_control_test.sv
// Self-checking bench for the clamp, offset and sync slicer control block
`timescale 1ns/1ps
module cosc_control_test;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWe = 1'b0;
    logic       regRe = 1'b0;
    logic       channelSelect = 1'b0;
    logic       clampPin = 1'b0;
    logic       coastPin = 1'b0;
    logic       vsyncPin = 1'b0;
    logic       drop = 1'b0;
    logic       stray = 1'b0;
    logic       lastClamp = 1'b0;
    logic       line0, line1, sl0, sl1;
    logic [7:0] regRdata;
    logic [2:0] clampActive;
    logic [2:0] clampToMid;
    logic       coastActive, autoOffsetEn, offsetUpdate, slicerOutputPin;
    logic [4:0] slicerThreshold;
    int         errors = 0;
    int         checks_done = 0;
    int         waited = 0;
    int         falls = 0;
    int         ups = 0;

    cosc_video_source cosc_video_source_inst (
        .clk(clk), .drop(drop), .stray(stray), .lineSync0(line0),
        .lineSync1(line1), .slicer0(sl0), .slicer1(sl1)
    );
    cosc_control cosc_control_inst (
        .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWe(regWe), .regRe(regRe), .regRdata(regRdata),
        .lineSyncChannelZero(line0), .lineSyncChannelOne(line1),
        .slicerSyncChannelZero(sl0), .slicerSyncChannelOne(sl1),
        .channelSelect(channelSelect), .clampPin(clampPin), .coastPin(coastPin),
        .vsyncPin(vsyncPin), .clampActive(clampActive), .clampToMid(clampToMid),
        .coastActive(coastActive), .autoOffsetEn(autoOffsetEn),
        .offsetUpdate(offsetUpdate), .slicerThreshold(slicerThreshold),
        .slicerOutputPin(slicerOutputPin)
    );

    initial forever #50 clk = ~clk;

    always @(posedge clk) begin
        lastClamp <= clampActive[0];
        if (lastClamp === 1'b1 && clampActive[0] === 1'b0) falls <= falls + 1;
        if (offsetUpdate === 1'b1) ups <= ups + 1;
    end

    // ==========
    // Bus, wait and compare tasks
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task automatic step;
        @(posedge clk);
        waited++;
        if (waited > 3000) begin
            errors++;
            final_report();
        end
    endtask : step
    // A spare cycle after each strobe keeps a strobe from being driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWe    <= 1'b1;
        @(posedge clk);
        regWe <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        regAddr <= a;
        regRe   <= 1'b1;
        @(posedge clk);
        regRe <= 1'b0;
        #1 check(regRdata, e);
        @(posedge clk);
    endtask : rdchk

    // ==========
    // Scenarios
    task automatic s_regs;
        logic [7:0] v [6];
        v = '{8'h2a, 8'h05, 8'h03, 8'h23, 8'hff, 8'hf9};
        rdchk(8'h18, 8'h20);
        rdchk(8'h19, 8'h08);
        rdchk(8'h1a, 8'h14);
        rdchk(8'h1b, 8'h58);
        rdchk(8'h1d, 8'h78);
        rdchk(8'h1e, 8'h00);
        check(slicerThreshold, 5'h0f);
        check(clampToMid, 3'h0);
        for (int i = 0; i < 6; i++) wr(8'h18 + i[7:0], v[i]);
        for (int i = 0; i < 6; i++) rdchk(8'h18 + i[7:0], v[i]);
        check(clampToMid, 3'h5);
        check(slicerThreshold, 5'h1f);
        check(autoOffsetEn, 1'b1);
        wr(8'h1b, 8'h03);
        wr(8'h18, 8'h20);
        rdchk(8'h1b, 8'h03);
        check(autoOffsetEn, 1'b0);
    endtask : s_regs
    task automatic meas(output int d, output int w);
        d = 0;
        w = 0;
        waited = 0;
        while (line0 !== 1'b0) step();
        while (line0 !== 1'b1) step();
        while (clampActive === 3'h0) begin
            d++;
            step();
        end
        while (clampActive === 3'h7) begin
            w++;
            step();
        end
        check(clampActive, 3'h0);
    endtask : meas
    task automatic s_clamp;
        int d0, w0, d1, w1;
        meas(d0, w0);
        check(12'(w0), 12'd3);
        wr(8'h19, 8'h0c);
        wr(8'h1a, 8'h07);
        meas(d1, w1);
        check(12'(d1 - d0), 12'd7);
        check(12'(w1), 12'd7);
    endtask : s_clamp
    task automatic s_ext(input logic pol);
        logic pa, ca;
        wr(8'h1b, {1'b1, pol, 6'h03});
        wr(8'h18, {2'b01, pol, 5'h10});
        for (int i = 0; i < 45; i++) begin
            clampPin <= (i % 3 == 0);
            coastPin <= (i % 5 < 2);
            @(posedge clk);
            if (i > 0) check(clampActive, {3{pa}});
            if (i > 0) check(coastActive, ca);
            pa = pol ~^ (i % 3 == 0);
            ca = pol ~^ (i % 5 < 2);
        end
    endtask : s_ext
    // Windows open mid-line so no clamp fall or update pulse straddles an edge
    task automatic upd(input logic [7:0] v, input int k, input int e);
        int f0, u0;
        wr(8'h1b, v);
        waited = 0;
        f0 = falls;
        while (falls == f0) step();
        repeat (5) @(posedge clk);
        f0 = falls;
        u0 = ups;
        for (int j = 0; j < 3 && v[4:3] == 2'h3; j++) begin
            vsyncPin <= 1'b1;
            @(posedge clk);
            vsyncPin <= 1'b0;
            repeat (30) @(posedge clk);
        end
        while (falls - f0 < k) step();
        repeat (5) @(posedge clk);
        check(12'(ups - u0), 12'(e));
    endtask : upd
    task automatic s_out(input logic [1:0] sel, input logic pol);
        logic e, src;
        wr(8'h1d, {5'h0f, pol, sel});
        for (int i = 0; i < 80; i++) begin
            channelSelect <= (i >= 40);
            @(posedge clk);
            if (i > 0) check(slicerOutputPin, e);
            src = sel[0] ? !(channelSelect ? line1 : line0) : (channelSelect ? sl1 : sl0);
            e = pol ~^ src;
        end
        channelSelect <= 1'b0;
    endtask : s_out
    task automatic s_sync(input logic [1:0] sel, input logic st, input int e);
        logic p;
        int n;
        n = 0;
        p = 1'b1;
        wr(8'h1d, {5'h0f, 1'b1, sel});
        stray <= st;
        waited = 0;
        while (line0 !== 1'b0) step();
        repeat (30) @(posedge clk);
        for (int i = 0; i < 400; i++) begin
            drop <= !st && sel == 2'h2 && i >= 80 && i < 160;
            @(posedge clk);
            n += (slicerOutputPin === 1'b1 && p === 1'b0);
            p = slicerOutputPin;
        end
        stray <= 1'b0;
        check(12'(n), 12'(e));
    endtask : s_sync

    // ==========
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        s_regs();
        s_clamp();
        s_ext(1'b1);
        s_ext(1'b0);
        wr(8'h18, 8'h20);
        upd(8'h23, 4, 4);
        upd(8'h2b, 32, 2);
        upd(8'h33, 64, 1);
        upd(8'h3b, 1, 3);
        upd(8'h03, 4, 0);
        for (int k = 0; k < 4; k++) s_out({1'b0, k[0]}, k[1]);
        s_sync(2'h2, 1'b0, 10);
        s_sync(2'h3, 1'b1, 10);
        s_sync(2'h1, 1'b1, 20);
        final_report();
    end
endmodule : cosc_control_test
